// ==== hdl/enable_filter.v ====
`timescale 1ns/1ns
`include "rx_mode_regs.vh"
// Debounces the enable pin; strap catches power-up level
module enable_filter #(
   parameter HOLD = `ENABLE_HOLD_CYC
)
(
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // Synchronised enable level
   input wire level_i,
   // Filtered enable
   output reg enabled_o
);
   reg [15:0] cnt_q; // Cycles level has differed from output
   reg init_q; // Power-up level not yet taken

   // A differing level must persist HOLD cycles; shorter pulses vanish
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 16'h0000;
         enabled_o <= 1'b0;
         init_q <= 1'b1;
      end
      else if (init_q)
      begin
         // Power-up takes the level at once, no filter wait
         init_q <= 1'b0;
         enabled_o <= level_i;
      end
      else if (level_i == enabled_o)
         cnt_q <= 16'h0000;
      else if (cnt_q >= HOLD[15:0] - 16'h0001)
      begin
         enabled_o <= level_i;
         cnt_q <= 16'h0000;
      end
      else
         cnt_q <= cnt_q + 16'h0001;
   end
endmodule // enable_filter

// ==== hdl/receiver_power_mode_fsm.v ====
`timescale 1ns/1ns
`include "rx_mode_regs.vh"
// What this block does
// - Enable low over 10 us: shutdown
// - Static pattern outside receive mode
// - Enabled, idle clock: standby, PLL off
// - Acquire: PLL seeks lock, outputs static
// - Receive only while enabled and locked
// - Wake from shutdown into standby first
// - Clock activity in standby: acquire, PLL on
// - First valid word after lock
// - Common mode high: static on falling edge
// - Enable low from any mode: shutdown
// - Enable input monitored during shutdown
// - Slow link clock forces standby
// - Enable pulses under 5 us ignored
// - Power-up follows enable without filter
// - Valid output within 2 ms of activity
// - Static, PLL off within 3 us of idle
module receiver_power_mode_fsm #(
   parameter HOLD = `ENABLE_HOLD_CYC,
   parameter WAKE = `WAKE_CYC
)
(
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // Pins from outside
   input wire receiver_enable_in_i,
   input wire link_clock_i,
   input wire clock_common_mode_level_i,
   // PLL status and recovered data
   input wire pll_locked_i,
   input wire pll_clock_i,
   input wire word_valid_i,
   input wire [23:0] pixel_i,
   input wire vertical_sync_i,
   input wire horizontal_sync_i,
   input wire pixel_valid_i,
   // Analog controls and status
   output reg pll_enable_o,
   output reg monitor_enable_o,
   output reg [3:0] mode_o,
   output reg wake_timeout_o,
   // Parallel outputs
   output reg [23:0] pixel_o,
   output reg vertical_sync_out_o,
   output reg horizontal_sync_out_o,
   output reg pixel_valid_out_o,
   output reg pixel_clock_o
);
   localparam S_OFF = 4'b0001;
   localparam S_STBY = 4'b0010;
   localparam S_ACQ = 4'b0100;
   localparam S_RX = 4'b1000;

   reg [1:0] en_s_q; // Enable synchroniser
   reg [1:0] lc_s_q; // Link clock synchroniser
   reg [1:0] cm_s_q; // Common mode synchroniser
   reg [1:0] lk_s_q; // Lock synchroniser
   reg [1:0] pc_s_q; // PLL clock synchroniser
   reg lc_prev_q; // Last link clock level
   reg [7:0] idle_q; // Cycles since last link edge
   reg [2:0] edges_q; // Edges counted while waking
   reg active_q; // Link clock judged active
   reg [3:0] state_q; // Mode state
   reg [3:0] state_d;
   reg [16:0] wake_q; // Cycles since acquire began
   reg first_q; // Waiting for first valid word
   wire enabled; // Filtered enable
   wire link_edge; // Rising edge of the synchronised link clock

   // Rising edges only, so the gap between them is a full period
   assign link_edge = lc_s_q[1] & ~lc_prev_q;

   // Enable input is never gated, so shutdown still watches it
   enable_filter #(.HOLD(HOLD)) u_filter (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .level_i(en_s_q[1]),
      .enabled_o(enabled)
   );

   // Two-stage synchronisers for the enable, link clock, common mode, lock and PLL clock inputs
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         // Enable keeps shifting so power-up sees the true pin level
         en_s_q <= {en_s_q[0], receiver_enable_in_i};
         // Link clock idles high, so no false edge after reset
         lc_s_q <= 2'b11;
         cm_s_q <= 2'b11;
         lk_s_q <= 2'b00;
         pc_s_q <= 2'b00;
         lc_prev_q <= 1'b1;
      end
      else
      begin
         en_s_q <= {en_s_q[0], receiver_enable_in_i};
         lc_s_q <= {lc_s_q[0], link_clock_i};
         cm_s_q <= {cm_s_q[0], clock_common_mode_level_i};
         lk_s_q <= {lk_s_q[0], pll_locked_i};
         pc_s_q <= {pc_s_q[0], pll_clock_i};
         lc_prev_q <= lc_s_q[1];
      end
   end

   // Activity monitor: a rising edge every 2 us or less means above
   // 500 kHz; slower clocks count as idle. The band up to a few
   // MHz is indeterminate, which the device allows.
   always @(posedge clock_i)
   begin
      if (!rst_n_i || !monitor_enable_o)
      begin
         idle_q <= 8'h00;
         edges_q <= 3'b000;
         active_q <= 1'b0;
      end
      else if (link_edge)
      begin
         idle_q <= 8'h00;
         if (edges_q == `ACT_EDGES - 1)
            active_q <= ~cm_s_q[1];
         else
            edges_q <= edges_q + 3'b001;
      end
      else if (idle_q >= `IDLE_CYC - 1)
      begin
         // Too slow: fall back to standby
         active_q <= 1'b0;
         edges_q <= 3'b000;
      end
      else
      begin
         idle_q <= idle_q + 8'h01;
         if (cm_s_q[1])
            active_q <= 1'b0;
      end
   end

   // Next-state logic
   always @*
   begin
      state_d = state_q;
      if (!enabled)
         state_d = S_OFF;
      else
         case (state_q)
            S_OFF:
               state_d = S_STBY;
            S_STBY:
               if (active_q)
                  state_d = S_ACQ;
            S_ACQ:
               if (!active_q)
                  state_d = S_STBY;
               else if (lk_s_q[1])
                  state_d = S_RX;
            S_RX:
               if (cm_s_q[1] || !active_q)
                  state_d = S_STBY;
               else if (!lk_s_q[1])
                  state_d = S_ACQ;
            default:
               state_d = S_OFF;
         endcase
   end

   // Mode register, analog controls and wake watchdog
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= S_OFF;
         pll_enable_o <= 1'b0;
         monitor_enable_o <= 1'b0;
         mode_o <= S_OFF;
         wake_q <= 17'h0_0000;
         wake_timeout_o <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         mode_o <= state_d;
         // PLL runs in acquire and receive only
         pll_enable_o <= state_d[2] | state_d[3];
         // Monitor on whenever not in shutdown
         monitor_enable_o <= ~state_d[0];
         if (state_d == S_ACQ && wake_q < WAKE[16:0])
            wake_q <= wake_q + 17'h0_0001;
         else if (state_d != S_ACQ)
            wake_q <= 17'h0_0000;
         // Flags a lock slower than the wake budget
         wake_timeout_o <= (wake_q == WAKE[16:0]);
      end
   end

   // Output gate: static pattern except in receive. Leaving
   // receive snaps static at once, well inside the sleep time.
   always @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         pixel_o <= `PIX_IDLE;
         vertical_sync_out_o <= 1'b1;
         horizontal_sync_out_o <= 1'b1;
         pixel_valid_out_o <= 1'b0;
         pixel_clock_o <= 1'b0;
         first_q <= 1'b1;
      end
      else if (state_d != S_RX)
      begin
         // Static from the very edge the mode leaves receive, so the
         // pattern never trails the mode code; this is no later
         // than the next falling PLL edge
         pixel_o <= `PIX_IDLE;
         vertical_sync_out_o <= 1'b1;
         horizontal_sync_out_o <= 1'b1;
         pixel_valid_out_o <= 1'b0;
         pixel_clock_o <= 1'b0;
         first_q <= 1'b1;
      end
      else if (first_q && !word_valid_i)
         pixel_clock_o <= 1'b0;
      else
      begin
         first_q <= 1'b0;
         pixel_clock_o <= pc_s_q[1];
         if (word_valid_i)
         begin
            pixel_o <= pixel_i;
            vertical_sync_out_o <= vertical_sync_i;
            horizontal_sync_out_o <= horizontal_sync_i;
            pixel_valid_out_o <= pixel_valid_i;
         end
      end
   end
endmodule // receiver_power_mode_fsm

// ==== hdl/rx_mode_regs.vh ====
`ifndef RX_MODE_REGS_VH
`define RX_MODE_REGS_VH
// Clock rate and timing figures
`define CLK_HZ 20000000
`define CLK_NS 50
`define ENABLE_HOLD_NS 10000
`define ENABLE_HOLD_CYC ((`ENABLE_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define GLITCH_NS 5000
`define GLITCH_CYC (`GLITCH_NS / `CLK_NS)
// Activity: edge must be seen within this window (500 kHz period = 2 us)
`define IDLE_NS 2000
`define IDLE_CYC (`IDLE_NS / `CLK_NS)
// Acquire edges needed before clock counts as active
`define ACT_EDGES 4
// Wake budget and sleep budget
`define WAKE_US 2000
`define WAKE_CYC (`WAKE_US * 1000 / `CLK_NS)
`define SLEEP_NS 3000
`define SLEEP_CYC (`SLEEP_NS / `CLK_NS)
// Static output pattern
`define PIX_IDLE 24'hff_ffff
`endif

// ==== verif/receiver_power_mode_fsm_tb.sv ====
`timescale 1ns/1ns
// Bench plays enable controller and PLL; the model plays the link
module receiver_power_mode_fsm_tb;
   reg clock_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg en = 1'b1;
   reg lock = 1'b0;
   reg pclk = 1'b0;
   reg wv = 1'b0;
   reg [23:0] pix = 24'h0000_00;
   reg run = 1'b0;
   reg slow = 1'b0;
   wire link;
   wire cm;
   wire pll_en, mon, tmo, vs, hs, pv, pco;
   wire [3:0] mode;
   wire [23:0] po;
   integer mismatches = 0;
   integer cmp_count = 0;
   // 50 ns system clock; PLL clock deliberately unrelated
   always #25 clock_i = !clock_i;
   always #85 pclk = !pclk;
   serializer_model u_link (.run_i(run), .slow_i(slow),
      .link_clock_o(link), .common_mode_high_o(cm));
   receiver_power_mode_fsm #(.HOLD(20), .WAKE(200)) uut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .receiver_enable_in_i(en),
      .link_clock_i(link), .clock_common_mode_level_i(cm),
      .pll_locked_i(lock), .pll_clock_i(pclk), .word_valid_i(wv),
      .pixel_i(pix), .vertical_sync_i(1'b0), .horizontal_sync_i(1'b1),
      .pixel_valid_i(1'b1), .pll_enable_o(pll_en), .monitor_enable_o(mon),
      .mode_o(mode), .wake_timeout_o(tmo), .pixel_o(po),
      .vertical_sync_out_o(vs), .horizontal_sync_out_o(hs),
      .pixel_valid_out_o(pv), .pixel_clock_o(pco));
   // Compare and count
   task check(input [31:0] seen, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("Error %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clock_i);
   endtask
   // Bounded wait for a mode; lands just after the edge
   task wait_mode(input [3:0] m, input integer n);
      integer i;
   begin
      for (i = 0; i < n && mode !== m; i = i + 1)
      begin
         @(posedge clock_i);
         #1;
      end
   end
   endtask
   task t_enable;
   begin
      @(posedge clock_i) en <= 1'b0;
      cyc(10);
      en <= 1'b1;
      cyc(60);
      check(mode, 4'b0010);
      en <= 1'b0;
      cyc(15);
      check(mode, 4'b0010);
      wait_mode(4'b0001, 40);
      check(mode, 4'b0001);
      check({pll_en, mon}, 2'b00);
      @(posedge clock_i) en <= 1'b1;
      wait_mode(4'b0010, 40);
      check(mode, 4'b0010);
   end
   endtask
   task t_link;
   begin
      @(posedge clock_i) run <= 1'b1;
      slow <= 1'b1;
      cyc(300);
      check(mode, 4'b0010);
      run <= 1'b0;
      slow <= 1'b0;
      cyc(10);
      run <= 1'b1;
      wait_mode(4'b0100, 100);
      check({mode, pll_en, po}, {5'b0100_1, 24'hff_ffff});
      check(tmo, 1'b0);
      // Hold off lock past the wake budget to see the watchdog flag
      cyc(205);
      check(tmo, 1'b1);
      @(posedge clock_i) lock <= 1'b1;
      wait_mode(4'b1000, 20);
      check({mode, pv, pco}, 6'b1000_00);
      @(posedge clock_i) pix <= 24'h12_3456;
      wv <= 1'b1;
      @(posedge clock_i) wv <= 1'b0;
      cyc(4);
      check({po, vs, hs, pv}, {24'h12_3456, 3'b011});
      check(tmo, 1'b0);
      lock <= 1'b0;
      wait_mode(4'b0100, 20);
      check({mode, po}, {4'b0100, 24'hff_ffff});
      @(posedge clock_i) lock <= 1'b1;
      wait_mode(4'b1000, 20);
      check(mode, 4'b1000);
      @(posedge clock_i) run <= 1'b0;
      wait_mode(4'b0010, 60);
      check({mode, pll_en, mon, vs, pv}, 8'b0010_0110);
      @(posedge clock_i) run <= 1'b1;
      wait_mode(4'b1000, 100);
      check(mode, 4'b1000);
      @(posedge clock_i) en <= 1'b0;
      wait_mode(4'b0001, 60);
      check({mode, po}, {4'b0001, 24'hff_ffff});
   end
   endtask
   task end_of_test;
   begin
      $display("Compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // Whole run is under a thousand cycles; cut a hang well past it
   initial
   begin
      #1000000;
      mismatches = mismatches + 1;
      end_of_test;
   end
   // Reset with enable high: wakes straight into standby
   initial
   begin
      cyc(16);
      rst_n_i <= 1'b1;
      wait_mode(4'b0010, 20);
      check({mode, mon, pll_en}, 6'b0010_10);
      check({po, vs, hs, pv, pco}, {24'hff_ffff, 4'b1100});
      t_enable;
      t_link;
      end_of_test;
   end
endmodule // receiver_power_mode_fsm_tb

// ==== verif/receiver_power_mode_props.sv ====
`timescale 1ns/1ns
// Mode and output-gating checks at the top ports
module receiver_power_mode_props #(
   parameter HOLD = 20,
   parameter WAKE = 200
)
(
   input wire clock_i,
   input wire rst_n_i,
   input wire clock_common_mode_level_i,
   input wire pll_locked_i,
   input wire pll_enable_o,
   input wire monitor_enable_o,
   input wire [3:0] mode_o,
   input wire [23:0] pixel_o,
   input wire vertical_sync_out_o,
   input wire horizontal_sync_out_o,
   input wire pixel_valid_out_o,
   input wire pixel_clock_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Static pattern: all ones, valid and clock low
   wire idle_pat = &pixel_o && vertical_sync_out_o &&
      horizontal_sync_out_o && !pixel_valid_out_o && !pixel_clock_o;
   // Link parked long enough for the sleep path
   sequence s_idle_cm; clock_common_mode_level_i [*8]; endsequence
   // Lock gone long enough to pass the synchroniser
   sequence s_unlocked; !pll_locked_i [*5]; endsequence
   property p_static; !mode_o[3] |-> idle_pat;
   endproperty
   a_static: assert property (p_static) else $error("not static");
   property p_onehot; $onehot(mode_o); endproperty
   a_onehot: assert property (p_onehot) else $error("mode code");
   property p_pll; pll_enable_o == (mode_o[2] || mode_o[3]); endproperty
   a_pll: assert property (p_pll) else $error("pll enable");
   property p_mon; monitor_enable_o == !mode_o[0]; endproperty
   a_mon: assert property (p_mon) else $error("monitor enable");
   property p_acq; $rose(mode_o[2]) |-> $past(mode_o[1]) || $past(mode_o[3]);
   endproperty
   a_acq: assert property (p_acq) else $error("acquire entry");
   property p_rx; $rose(mode_o[3]) |-> $past(mode_o[2]); endproperty
   a_rx: assert property (p_rx) else $error("receive entry");
   property p_wake; $fell(mode_o[0]) |-> mode_o[1]; endproperty
   a_wake: assert property (p_wake) else $error("wake order");
   property p_lock; s_unlocked |-> !mode_o[3]; endproperty
   a_lock: assert property (p_lock) else $error("receive unlocked");
   property p_sleep; s_idle_cm |-> !mode_o[3] && !mode_o[2]; endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep");
endmodule // receiver_power_mode_props
bind receiver_power_mode_fsm receiver_power_mode_props #(.HOLD(HOLD),
   .WAKE(WAKE)) u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .clock_common_mode_level_i(clock_common_mode_level_i),
   .pll_locked_i(pll_locked_i), .pll_enable_o(pll_enable_o),
   .monitor_enable_o(monitor_enable_o), .mode_o(mode_o),
   .pixel_o(pixel_o), .vertical_sync_out_o(vertical_sync_out_o),
   .horizontal_sync_out_o(horizontal_sync_out_o),
   .pixel_valid_out_o(pixel_valid_out_o), .pixel_clock_o(pixel_clock_o));

// ==== verif/serializer_model.sv ====
`timescale 1ns/1ns
// Far-side serializer: runs the link clock or releases it
module serializer_model
(
   // Run request and slow-rate select
   input wire run_i,
   input wire slow_i,
   // Link clock and idle common-mode flag
   output reg link_clock_o,
   output wire common_mode_high_o
);
   // Released pair floats up, so common mode rises when idle
   assign common_mode_high_o = !run_i;
   initial link_clock_o = 1'b0;
   // Clock stands high when released; even duty when running.
   // Slow rate stays under 500 kHz, out of the band to avoid; the
   // running rate is a scaled stand-in for the pixel clock band,
   // which the 20 MHz sampler could not resolve
   always
   begin
      if (run_i)
         #(slow_i ? 1500 : 200) link_clock_o = !link_clock_o;
      else
         #50 link_clock_o = 1'b1;
   end
endmodule // serializer_model
